// ===== design/bus_boot_wait_priority.sv
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
// Operation
// - Four ports decoded at six-bit base
// - Status read shows controller interrupt bit 7
// - Interrupt routed to one selected line
// - Boot ROM answers reads at reset page
// - Window decodes upper address bits only
// - Bank and routine select upper ROM bits
// - Waits only when enabled, qualifying cycles
// - Boot ROM reads get five waits
// - I/O and DMA get two/three/four waits
// - Inhibit blocks ROM and phantom
// - Four-bit weighted arbitration priority output
// - Serial bit zero runs motors, one stops
// - Motor control off keeps motors on
// - Serial write bit0 low ends boot
// - Status port offset two, bit seven
// - Phantom when boot and no own DMA
module bus_boot_wait_priority #(
  parameter int SYS_ADDR_W = 24,
  parameter logic [31:0] RESET_PAGE = 32'h0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [SYS_ADDR_W-1:0] sys_addr,
  input wire logic [7:0] sys_data_in,
  input wire logic sys_mem_read,
  input wire logic sys_io_in,
  input wire logic sys_io_out,
  input wire logic sys_strobe,
  input wire logic sys_own_dma,
  input wire logic fdc_int,
  input wire logic serial_in,
  output logic [7:0] sys_data_out,
  output logic sys_data_oe,
  output logic sys_wait,
  output logic phantom,
  output logic rom_select,
  output logic [10:0] rom_addr,
  output logic port_select,
  output logic [7:0] vectored_int,
  output logic general_int,
  output logic [3:0] dma_priority,
  output logic serial_out,
  output logic motor_on,
  output logic irq
);
  import bbw_pkg::*;

  // Address width must cover the port block and the boot page
  if (SYS_ADDR_W < 16 || SYS_ADDR_W > 32) begin : g_bad_width
    $error("SYS_ADDR_W must lie in 16..32");
  end

  localparam int SW = SYS_ADDR_W + 15;

  // Two-flop synchroniser for every backplane input
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {sys_addr, sys_data_in, sys_mem_read, sys_io_in,
                sys_io_out, sys_strobe, sys_own_dma, fdc_int, serial_in};
      sync2 <= sync1;
    end
  end

  logic [SYS_ADDR_W-1:0] s_addr;
  logic [7:0] s_data;
  logic s_mrd, s_iin, s_iout, s_stb, s_dma, s_int, s_ser;
  assign {s_addr, s_data, s_mrd, s_iin, s_iout, s_stb, s_dma, s_int,
          s_ser} = sync2;

  logic [CFG_W-1:0] cfg;
  logic boot_active, ser_latch;
  logic [IRQ_W-1:0] irq_stat, irq_mask;
  cyc_state_t state;
  logic [2:0] wait_cnt;

  // Wait count for I/O and DMA cycles from the three-way setting
  function automatic logic [2:0] io_waits(input logic [1:0] sel);
    case (sel)
      WSEL_A: io_waits = IO_WAITS_A;
      WSEL_B: io_waits = IO_WAITS_B;
      default: io_waits = IO_WAITS_NONE;
    endcase
  endfunction : io_waits

  logic inhibit, wait_en;
  logic [5:0] port_base;
  logic [3:0] route;
  assign inhibit = cfg[CFG_INH_BIT];
  assign wait_en = cfg[CFG_WEN_BIT];
  assign port_base = cfg[CFG_BASE_LSB +: 6];
  assign route = cfg[CFG_ROUTE_LSB +: 4];

  // Backplane decode
  logic io_hit, rom_hit, start;
  assign io_hit = (s_iin | s_iout) && s_addr[7:2] == port_base;
  // page match on upper bits
  // Low byte ignored, so an unaligned reset vector still lands inside
  assign rom_hit = s_mrd && boot_active && !inhibit &&
                   s_addr[SYS_ADDR_W-1:8] == RESET_PAGE[SYS_ADDR_W-1:8];
  assign start = state == CYC_IDLE && s_stb;
  assign port_select = io_hit && !s_dma;

  assign phantom = boot_active && !inhibit && !s_dma;
  assign rom_select = rom_hit && !s_dma;
  // bank and routine form ROM page
  assign rom_addr = {cfg[CFG_BANK_BIT], cfg[CFG_ROUT_LSB +: 2],
                     s_addr[7:0]};

  // Cycle sequencer: stretches qualifying cycles by a fixed count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= CYC_IDLE;
      wait_cnt <= '0;
    end else begin
      case (state)
        CYC_IDLE: begin
          if (s_stb && wait_en && (rom_select || port_select || s_dma)) begin
            state <= CYC_WAIT;
            wait_cnt <= rom_select ? ROM_WAITS : io_waits(
                        cfg[CFG_WSEL_LSB +: 2]);
          end else if (s_stb) begin
            state <= CYC_DONE;
          end
        end
        CYC_WAIT: begin
          wait_cnt <= wait_cnt - 3'h1;
          if (wait_cnt == 3'h1)
            state <= CYC_DONE;
        end
        CYC_DONE: begin
          if (!s_stb)
            state <= CYC_IDLE;
        end
        default: state <= CYC_IDLE;
      endcase
    end
  end
  assign sys_wait = state == CYC_WAIT;

  // Read data for status and serial ports; others keep sys_data_oe low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_data_out <= '0;
      sys_data_oe <= 1'b0;
    end else if (start && port_select && s_iin) begin
      sys_data_oe <= s_addr[1:0] == REL_STATUS ||
                     s_addr[1:0] == REL_SERIAL;
      sys_data_out <= '0;
      if (s_addr[1:0] == REL_STATUS)
        sys_data_out[DATA_TOP_BIT] <= s_int;
      else if (s_addr[1:0] == REL_SERIAL)
        sys_data_out[DATA_TOP_BIT] <= s_ser;
    end else if (!s_stb) begin
      sys_data_oe <= 1'b0;
    end
  end

  logic ser_wr;
  assign ser_wr = start && port_select && s_iout &&
                  s_addr[1:0] == REL_SERIAL;

  // Boot state and serial latch; a reset brings both back
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_active <= 1'b1;
      ser_latch <= 1'b0;
    end else if (ser_wr) begin
      ser_latch <= s_data[DATA_TOP_BIT];
      if (!s_data[SER_BOOT_BIT])
        boot_active <= 1'b0;
    end
  end
  assign serial_out = ser_latch;
  assign motor_on = cfg[CFG_MOTEN_BIT] ? !ser_latch : 1'b1;

  always_comb begin
    vectored_int = '0;
    if (route < ROUTE_GENERAL)
      vectored_int[route[2:0]] = s_int;
    general_int = route == ROUTE_GENERAL && s_int;
  end
  assign dma_priority = cfg[CFG_PRIO_LSB +: 4];

  // AHB-Lite slave: zero-wait, always OKAY
  logic wr_pend;
  logic [7:0] wr_addr;
  logic acc;
  assign acc = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= acc && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // Register writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= CFG_RESET;
      irq_mask <= '0;
    end else if (wr_pend) begin
      if (wr_addr == CFG_OFS)
        cfg <= hwdata[CFG_W-1:0];
      if (wr_addr == MASK_OFS)
        irq_mask <= hwdata[IRQ_W-1:0];
    end
  end

  // Sticky events; a new event beats the read that clears
  logic int_d;
  logic [IRQ_W-1:0] ev;
  logic rd_irq;
  assign ev = {ser_wr, s_int && !int_d,
               ser_wr && !s_data[SER_BOOT_BIT] && boot_active};
  assign rd_irq = acc && !hwrite && haddr[7:0] == IRQ_OFS;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= '0;
      int_d <= 1'b0;
    end else begin
      int_d <= s_int;
      irq_stat <= (rd_irq ? '0 : irq_stat) | ev;
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // Read data captured in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (acc && !hwrite) begin
      hrdata <= '0;
      case (haddr[7:0])
        CFG_OFS: hrdata[CFG_W-1:0] <= cfg;
        STAT_OFS: begin
          hrdata[ST_BOOT_BIT] <= boot_active && !inhibit;
          hrdata[ST_INT_BIT] <= s_int;
          hrdata[ST_SER_BIT] <= ser_latch;
          hrdata[ST_MOTOR_BIT] <= motor_on;
        end
        IRQ_OFS: hrdata[IRQ_W-1:0] <= irq_stat;
        MASK_OFS: hrdata[IRQ_W-1:0] <= irq_mask;
        default: hrdata <= '0;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_rom_five_waits: assert property (
    (state == CYC_IDLE && s_stb && wait_en && rom_select) |=>
    sys_wait [*5] ##1 !sys_wait)
    else $error("boot ROM read not stretched by five");
  a_no_wait_off: assert property (
    !wait_en && state == CYC_IDLE |=> !sys_wait)
    else $error("wait inserted while disabled");
  a_phantom_inh: assert property (
    inhibit |-> !phantom && !rom_select)
    else $error("phantom or ROM while inhibited");
  a_phantom_dma: assert property (
    s_dma |-> !phantom)
    else $error("phantom during own DMA cycle");
  a_boot_end: assert property (
    ser_wr && !s_data[SER_BOOT_BIT] |=> !boot_active [*3])
    else $error("boot not ended by serial write");
  a_motor_ctl: assert property (
    cfg[CFG_MOTEN_BIT] && ser_wr |=>
    motor_on == !$past(s_data[DATA_TOP_BIT]))
    else $error("motor does not follow serial bit");
  a_motor_free: assert property (
    !cfg[CFG_MOTEN_BIT] |-> motor_on)
    else $error("motor off without motor control");
  a_status_bit: assert property (
    start && port_select && s_iin && s_addr[1:0] == REL_STATUS |=>
    sys_data_oe && sys_data_out[DATA_TOP_BIT] == $past(s_int))
    else $error("status port does not show interrupt");
  a_io_waits: assert property (
    (state == CYC_IDLE && s_stb && wait_en && !rom_select &&
     port_select && cfg[CFG_WSEL_LSB +: 2] == WSEL_A) |=>
    sys_wait [*2] ##1 !sys_wait)
    else $error("I/O cycle wait count wrong");

  c_rom_read: cover property (start && rom_select && wait_en);
  c_boot_end: cover property (ser_wr ##1 !boot_active);
  c_irq: cover property (irq);
endmodule : bus_boot_wait_priority

// ===== shared/bbw_pkg.sv
package bbw_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS = 8'h0c;
  // Configuration field positions (former switch and jumper settings)
  localparam int CFG_BASE_LSB = 0;
  localparam int CFG_ROUT_LSB = 6;
  localparam int CFG_BANK_BIT = 8;
  localparam int CFG_WEN_BIT = 9;
  localparam int CFG_WSEL_LSB = 10;
  localparam int CFG_INH_BIT = 12;
  localparam int CFG_MOTEN_BIT = 13;
  localparam int CFG_PRIO_LSB = 14;
  localparam int CFG_ROUTE_LSB = 18;
  localparam int CFG_W = 22;
  // Base CCH, no interrupt route, waits off, boot allowed
  localparam logic [CFG_W-1:0] CFG_RESET = 22'h3c0033;
  localparam logic [3:0] ROUTE_GENERAL = 4'h8;
  // Status register bits
  localparam int ST_BOOT_BIT = 0;
  localparam int ST_INT_BIT = 1;
  localparam int ST_SER_BIT = 2;
  localparam int ST_MOTOR_BIT = 3;
  // Sticky event bits
  localparam int IRQ_BOOT_END = 0;
  localparam int IRQ_FDC = 1;
  localparam int IRQ_SER = 2;
  localparam int IRQ_W = 3;
  // Backplane port map
  localparam logic [1:0] REL_STATUS = 2'h2;
  localparam logic [1:0] REL_SERIAL = 2'h3;
  localparam int DATA_TOP_BIT = 7;
  localparam int SER_BOOT_BIT = 0;
  // Wait-state counts
  localparam logic [2:0] ROM_WAITS = 3'h5;
  localparam logic [2:0] IO_WAITS_A = 3'h2;
  localparam logic [2:0] IO_WAITS_B = 3'h3;
  localparam logic [2:0] IO_WAITS_NONE = 3'h4;
  localparam logic [1:0] WSEL_A = 2'h0;
  localparam logic [1:0] WSEL_B = 2'h1;
  typedef enum logic [2:0] {
    CYC_IDLE = 3'b001,
    CYC_WAIT = 3'b010,
    CYC_DONE = 3'b100
  } cyc_state_t;
endpackage : bbw_pkg

// ===== testbench/backplane_host.sv
`timescale 1ns/1ps
// Backplane host: one strobed cycle at a time
module backplane_host (
  input wire logic hclk,
  input wire logic sys_wait,
  input wire logic [7:0] sys_data_out,
  output logic [23:0] sys_addr,
  output logic [7:0] sys_data_in,
  output logic sys_mem_read,
  output logic sys_io_in,
  output logic sys_io_out,
  output logic sys_strobe
);
  // Idle bus at time zero
  initial begin
    sys_addr = 24'h0;
    sys_data_in = 8'h0;
    sys_mem_read = 1'b0;
    sys_io_in = 1'b0;
    sys_io_out = 1'b0;
    sys_strobe = 1'b0;
  end
  // Host holds no memory, nothing contends
  // Sole temporary master, no clash
  // Kind 0 memory read, 1 port read, 2 port write
  task automatic cycle(input int k, input logic [23:0] a,
    input logic [7:0] d, output int w, output logic [7:0] q);
    @(posedge hclk);
    sys_addr <= a;
    sys_data_in <= d;
    sys_mem_read <= k == 0;
    sys_io_in <= k == 1;
    sys_io_out <= k == 2;
    sys_strobe <= 1'b1;
    w = 0;
    // Strobe held long enough for the longest stretch
    repeat (16) begin
      @(negedge hclk);
      if (sys_wait === 1'b1) w++;
    end
    q = sys_data_out;
    @(posedge hclk);
    sys_strobe <= 1'b0;
    // Released data no longer shows the last value
    sys_data_in <= ~d;
    repeat (4) @(posedge hclk);
  endtask : cycle
endmodule : backplane_host

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import bbw_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rs, ps, oe;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [23:0] sys_addr;
  logic [7:0] sys_data_in, sys_data_out, q, vectored_int;
  logic sys_mem_read, sys_io_in, sys_io_out, sys_strobe, sys_own_dma;
  logic fdc_int, serial_in, sys_data_oe, sys_wait, phantom, rom_select;
  logic port_select, general_int, serial_out, motor_on, irq;
  logic [10:0] rom_addr, ra;
  logic [3:0] dma_priority;
  int n_errors = 0, tests_run = 0, waits;
  bus_boot_wait_priority bus_boot_wait_priority_i (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sys_addr,
    .sys_data_in, .sys_mem_read, .sys_io_in, .sys_io_out, .sys_strobe,
    .sys_own_dma, .fdc_int, .serial_in, .sys_data_out, .sys_data_oe,
    .sys_wait, .phantom, .rom_select, .rom_addr, .port_select,
    .vectored_int, .general_int, .dma_priority, .serial_out, .motor_on,
    .irq);
  backplane_host backplane_host_i (.hclk, .sys_wait, .sys_data_out,
    .sys_addr, .sys_data_in, .sys_mem_read, .sys_io_in, .sys_io_out,
    .sys_strobe);
  // Free-running 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // One single AHB-Lite transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    @(negedge hclk);
  endtask : ahb
  // Config written relative to reset so tests stay independent
  task automatic setc(int l, logic [31:0] m, logic [31:0] v);
    ahb(1'b1, CFG_OFS, (32'(CFG_RESET) & ~(m << l)) | (v << l));
  endtask : setc
  // Backplane cycle with decode outputs sampled mid-strobe
  task automatic bp(int k, logic [23:0] a, logic [7:0] d);
    fork
      backplane_host_i.cycle(k, a, d, waits, q);
      begin
        repeat (12) @(negedge hclk);
        rs = rom_select;
        ra = rom_addr;
        ps = port_select;
        oe = sys_data_oe;
      end
    join
  endtask : bp
  task automatic rst;
    @(posedge hclk) hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(negedge hclk);
  endtask : rst
  task print_verdict;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  // Watchdog: the run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    print_verdict;
  end
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, hresetn} = '0;
    {fdc_int, serial_in, sys_own_dma} = '0;
    hsize = 3'h2;
    rst;
    chk(phantom, 1);
    chk({serial_out, motor_on, irq, hresp}, 4'h4);
    ahb(0, CFG_OFS, 0);
    chk(rd, CFG_RESET);
    ahb(0, 8'h10, 0);
    chk(rd, 0);
    @(posedge hclk) fdc_int <= 1'b1;
    bp(1, 24'h0000ce, 8'h0);
    chk({ps, oe, q}, 10'h380);
    bp(1, 24'h0000d2, 8'h0);
    chk(ps, 0);
    setc(CFG_BASE_LSB, 'h3f, 'h30);
    bp(1, 24'h0000c2, 8'h0);
    chk({ps, oe, q}, 10'h380);
    for (int r = 0; r < 10; r++) begin
      setc(CFG_ROUTE_LSB, 'hf, r);
      chk({general_int, vectored_int}, r < 9 ? 32'h1 << r : 32'h0);
    end
    for (int s = 0; s < 4; s++) begin
      setc(CFG_WEN_BIT, 'h7, 1 | s << 1);
      bp(1, 24'h0000cd, 8'h0);
      chk(waits, s < 2 ? s + 2 : 4);
    end
    bp(1, 24'h000010, 8'h0);
    chk(waits, 0);
    // Own DMA cycle with waits on: I/O-class stretch, never the ROM
    @(posedge hclk) sys_own_dma <= 1'b1;
    bp(0, 24'h0000f0, 8'h0);
    chk({rs, waits[3:0]}, 5'h04);
    @(posedge hclk) sys_own_dma <= 1'b0;
    bp(0, 24'h0000f0, 8'h0);
    chk({rs, waits[3:0], ra}, {5'h15, 11'h0f0});
    chk(rs, 1);
    bp(0, 24'h0001f0, 8'h0);
    chk({rs, waits[3:0]}, 0);
    for (int i = 0; i < 8; i++) begin
      setc(CFG_ROUT_LSB, 'h7, i);
      bp(0, 24'h000012, 8'h0);
      chk({rs, waits[3:0], ra}, {5'h10, i[2:0], 8'h12});
    end
    setc(CFG_PRIO_LSB, 'hf, 9);
    chk(dma_priority, 9);
    @(posedge hclk) sys_own_dma <= 1'b1;
    repeat (3) @(negedge hclk);
    chk(phantom, 0);
    @(posedge hclk) sys_own_dma <= 1'b0;
    @(posedge hclk) fdc_int <= 1'b0;
    ahb(0, IRQ_OFS, 0);
    @(posedge hclk) fdc_int <= 1'b1;
    repeat (4) @(negedge hclk);
    chk(irq, 0);
    ahb(1, MASK_OFS, 32'h2);
    chk(irq, 1);
    ahb(0, IRQ_OFS, 0);
    chk(irq, 0);
    chk(rd, 32'h2);
    setc(CFG_MOTEN_BIT, 1, 1);
    bp(2, 24'h0000cf, 8'h81);
    chk({motor_on, serial_out}, 2'h1);
    bp(2, 24'h0000cf, 8'h01);
    chk({motor_on, serial_out}, 2'h2);
    setc(CFG_MOTEN_BIT, 1, 0);
    ahb(1, MASK_OFS, 32'h1);
    bp(2, 24'h0000cf, 8'h81);
    chk({motor_on, serial_out, phantom, irq}, 4'he);
    bp(2, 24'h0000cf, 8'h80);
    chk({phantom, irq}, 2'h1);
    ahb(0, IRQ_OFS, 0);
    chk(irq, 0);
    chk(rd, 32'h5);
    bp(0, 24'h0000f0, 8'h0);
    chk(rs, 0);
    rst;
    chk({phantom, serial_out}, 2'h2);
    setc(CFG_INH_BIT, 1, 1);
    bp(0, 24'h0000f0, 8'h0);
    chk({phantom, rs}, 0);
    print_verdict;
  end
endmodule : testbench
